// file: src/astrc_pkg.sv
// Function
// - Shifter-empty reads 1 while shift register idle
// - Nine-bit transmit sends ninth bit as MSB
// - All nine bits move to shifter together
// - Enabling transmitter with empty buffer flags empty
// - Receive recovery runs at sixteen times baud
// - Received characters enter two-entry FIFO
// - Reception needs receive, async and port enables
// - Start bit rechecked at half bit, else dropped
// - Data bits majority sampled at bit centre
// - Low stop bit marks framing error
// - Finished character pushed, available flag set
// - Data read returns and removes oldest character
// - Available flag tracks unread FIFO contents while reception enabled
// - Framing error stored per FIFO entry
// - Framing error cleared by reading its entry or by port disable
// - Third character while full sets overrun
// - Overrun cleared by receive or port disable
// - Nine-bit receive stores ninth bit per entry
// - Address detect in nine-bit receive admits only ninth-bit-set characters
// - Frame: start, eight/nine data, stop, idle high
// - Data LSB first, shared format and rate
// - Buffer-empty flag high when enabled and empty
// - Polarity bit inverts transmitted line
package astrc_pkg;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_TXDATA = 8'h08;
   localparam logic [7:0] REG_RXDATA = 8'h0c;
   localparam logic [7:0] REG_BAUD = 8'h10;
   localparam int CTRL_PORT_EN = 0;
   localparam int CTRL_SYNC = 1;
   localparam int CTRL_TX_EN = 2;
   localparam int CTRL_CRX_EN = 3;
   localparam int CTRL_TX9 = 4;
   localparam int CTRL_RX9 = 5;
   localparam int CTRL_ADDR_DET = 6;
   localparam int CTRL_POL = 7;
   localparam int CTRL_TX_NINTH = 8;
   localparam int CTRL_W = 9;
   localparam int ST_SHIFT_EMPTY = 0;
   localparam int ST_TXBUF_EMPTY = 1;
   localparam int ST_RX_AVAIL = 2;
   localparam int ST_FRAME_ERR = 3;
   localparam int ST_OVERRUN = 4;
   localparam int ST_RX_NINTH = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
   localparam logic [15:0] BAUD_RESET = 16'h0000;
   localparam logic [3:0] TICKS_LAST = 4'hf;
   localparam logic [3:0] SAMPLE_A = 4'h7;
   localparam logic [3:0] SAMPLE_C = 4'h9;
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } astrc_rx_state_t;

   typedef struct packed {
      logic frame_err;
      logic ninth;
      logic [7:0] data;
   } astrc_entry_t;

   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [15:0] baud_div;
      logic [15:0] baud_cnt;
      logic [8:0] thr_data;
      logic thr_full;
      logic [10:0] transmit_shift_register;
      logic tx_busy;
      logic [3:0] tx_bits;
      logic [3:0] tx_ticks;
      logic tx_line;
      logic rx_meta;
      logic rx_sync;
      logic rx_prev;
      astrc_rx_state_t rx_state;
      logic [3:0] rx_ticks;
      logic [3:0] rx_bits;
      logic [2:0] samples;
      logic [8:0] receive_shift_register;
      astrc_entry_t [1:0] fifo;
      logic wptr;
      logic rptr;
      logic [1:0] count;
      logic overrun;
      logic [31:0] prdata;
      logic slverr;
      logic rd_ok;
   } astrc_state_t;
endpackage : astrc_pkg

// file: src/astrc_core.sv
`timescale 1ns/1ps
module astrc_core (
   // Clock, reset and clock enable.
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // APB slave.
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Serial lines.
   input wire logic serial_receive_line_i,
   output logic serial_transmit_line_o,
   // Status flags.
   output logic transmit_buffer_empty_flag_o,
   output logic receive_data_available_flag_o
);
   astrc_pkg::astrc_state_t s_r;
   astrc_pkg::astrc_state_t s_nxt;

   logic port_en;
   logic rx_active;
   logic tx_active;
   logic tick;
   logic access;
   logic wr_acc;
   logic rd_acc;
   logic pop;
   logic shifter_empty;
   logic txbuf_empty;
   logic rx_avail;
   logic frame_err;
   logic rx_ninth;
   logic [8:0] char_bits;
   logic maj;
   astrc_pkg::astrc_entry_t head;
   logic [31:0] rd_val;

   // Two of three samples decide a bit, so one noisy sample cannot flip it.
   function automatic logic majority(input logic [2:0] v);
      majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction : majority

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction : hit

   // True while the receive FIFO holds at least one unread entry.
   function automatic logic unread(input logic [1:0] c);
      unread = (c != 2'h0);
   endfunction : unread

   // True for the word addresses that the block answers without error.
   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, astrc_pkg::REG_CTRL) |
               hit(a, astrc_pkg::REG_STATUS) |
               hit(a, astrc_pkg::REG_TXDATA) |
               hit(a, astrc_pkg::REG_RXDATA) |
               hit(a, astrc_pkg::REG_BAUD);
   endfunction : mapped

   // True at the tick that follows the three centre samples of a bit.
   function automatic logic decide(input logic [3:0] t);
      decide = (t == astrc_pkg::SAMPLE_C + 4'h1);
   endfunction : decide

   assign port_en = s_r.ctrl[astrc_pkg::CTRL_PORT_EN];
   assign rx_active = s_r.ctrl[astrc_pkg::CTRL_CRX_EN] &
                      ~s_r.ctrl[astrc_pkg::CTRL_SYNC] & port_en;
   assign tx_active = s_r.ctrl[astrc_pkg::CTRL_TX_EN] &
                      ~s_r.ctrl[astrc_pkg::CTRL_SYNC] & port_en;
   // One tick every baud_div plus one clocks; both directions count sixteen per bit.
   // Rewriting the divisor restarts the count so a new rate acts at once.
   assign tick = (s_r.baud_cnt == s_r.baud_div);
   assign head = s_r.fifo[s_r.rptr];
   assign shifter_empty = ~s_r.tx_busy;
   assign txbuf_empty = tx_active & ~s_r.thr_full;
   // The per-entry status follows the oldest entry and reads 0 when the
   // FIFO is empty, so a stale entry never shows through.
   assign rx_avail = rx_active & unread(s_r.count);
   assign frame_err = unread(s_r.count) & head.frame_err;
   assign rx_ninth = unread(s_r.count) & head.ninth;
   assign maj = majority(s_r.samples);

   // The answer comes one cycle after setup, once read data is latched.
   assign access = psel_i & penable_i & ce_i & s_r.rd_ok;
   assign wr_acc = access & pwrite_i & ~s_r.slverr;
   assign rd_acc = access & ~pwrite_i & ~s_r.slverr;
   assign pop = rd_acc & hit(paddr_i, astrc_pkg::REG_RXDATA) &
                unread(s_r.count);

   // Handshake outputs are combinational; read data and the line are
   // registered so that they never glitch within a cycle.
   assign pready_o = access;
   assign prdata_o = s_r.prdata;
   assign pslverr_o = access & s_r.slverr;
   assign serial_transmit_line_o = s_r.tx_line;
   assign transmit_buffer_empty_flag_o = txbuf_empty;
   assign receive_data_available_flag_o = rx_avail;

   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (paddr_i)
         astrc_pkg::REG_CTRL: begin
            rd_val[astrc_pkg::CTRL_W-1:0] = s_r.ctrl;
         end
         astrc_pkg::REG_STATUS: begin
            rd_val[astrc_pkg::ST_SHIFT_EMPTY] = shifter_empty;
            rd_val[astrc_pkg::ST_TXBUF_EMPTY] = txbuf_empty;
            rd_val[astrc_pkg::ST_RX_AVAIL] = rx_avail;
            rd_val[astrc_pkg::ST_FRAME_ERR] = frame_err;
            rd_val[astrc_pkg::ST_OVERRUN] = s_r.overrun;
            rd_val[astrc_pkg::ST_RX_NINTH] = rx_ninth;
         end
         astrc_pkg::REG_RXDATA: begin
            if (unread(s_r.count)) begin
               rd_val[7:0] = head.data;
            end
         end
         astrc_pkg::REG_BAUD: begin
            rd_val[15:0] = s_r.baud_div;
         end
         default: begin
            rd_val = 32'h0000_0000;
         end
      endcase
   end

   // Character assembled from the shift register, nine or eight bits.
   always_comb begin
      if (s_r.ctrl[astrc_pkg::CTRL_RX9]) begin
         char_bits = s_r.receive_shift_register;
      end else begin
         char_bits = {1'b0, s_r.receive_shift_register[8:1]};
      end
   end

   always_comb begin
      logic push;
      logic keep;
      logic [3:0] nbits;
      push = 1'b0;
      keep = 1'b0;
      nbits = astrc_pkg::BITS_EIGHT;
      s_nxt = s_r;

      // APB: latch read data during the cycle before the answer.
      if (psel_i & ~access) begin
         s_nxt.prdata = rd_val;
         s_nxt.slverr = ~mapped(paddr_i);
         s_nxt.rd_ok = 1'b1;
      end else begin
         s_nxt.rd_ok = 1'b0;
      end
      if (wr_acc & hit(paddr_i, astrc_pkg::REG_CTRL)) begin
         s_nxt.ctrl = pwdata_i[astrc_pkg::CTRL_W-1:0];
      end
      if (wr_acc & hit(paddr_i, astrc_pkg::REG_BAUD)) begin
         s_nxt.baud_div = pwdata_i[15:0];
         s_nxt.baud_cnt = 16'h0000;
      end else if (tick) begin
         s_nxt.baud_cnt = 16'h0000;
      end else begin
         s_nxt.baud_cnt = s_r.baud_cnt + 16'h0001;
      end

      // Transmitter: the shift register reloads as soon as it is idle.
      if (tx_active & ~s_r.tx_busy & s_r.thr_full) begin
         if (s_r.ctrl[astrc_pkg::CTRL_TX9]) begin
            s_nxt.transmit_shift_register = {1'b1, s_r.thr_data, 1'b0};
            s_nxt.tx_bits = astrc_pkg::BITS_NINE + 4'h1;
         end else begin
            s_nxt.transmit_shift_register = {2'b11, s_r.thr_data[7:0], 1'b0};
            s_nxt.tx_bits = astrc_pkg::BITS_EIGHT + 4'h1;
         end
         s_nxt.thr_full = 1'b0;
         s_nxt.tx_busy = 1'b1;
         s_nxt.tx_ticks = 4'h0;
      end else if (s_r.tx_busy & tick) begin
         if (s_r.tx_ticks == astrc_pkg::TICKS_LAST) begin
            s_nxt.tx_ticks = 4'h0;
            s_nxt.transmit_shift_register = {1'b1, s_r.transmit_shift_register[10:1]};
            if (s_r.tx_bits == 4'h0) begin
               s_nxt.tx_busy = 1'b0;
            end else begin
               s_nxt.tx_bits = s_r.tx_bits - 4'h1;
            end
         end else begin
            s_nxt.tx_ticks = s_r.tx_ticks + 4'h1;
         end
      end

      // Transmit holding buffer takes the ninth bit with the data. It comes
      // after the reload, so a write in the cycle that empties the buffer
      // into the shifter is kept instead of being lost.
      if (wr_acc & hit(paddr_i, astrc_pkg::REG_TXDATA) & port_en) begin
         s_nxt.thr_data = {s_r.ctrl[astrc_pkg::CTRL_TX_NINTH],
                           pwdata_i[7:0]};
         s_nxt.thr_full = 1'b1;
      end
      s_nxt.tx_line = (~s_nxt.tx_busy | s_nxt.transmit_shift_register[0]) ^
                      s_r.ctrl[astrc_pkg::CTRL_POL];

      // Receive line synchroniser and edge history.
      s_nxt.rx_meta = serial_receive_line_i;
      s_nxt.rx_sync = s_r.rx_meta;
      s_nxt.rx_prev = s_r.rx_sync;

      if (s_r.ctrl[astrc_pkg::CTRL_RX9]) begin
         nbits = astrc_pkg::BITS_NINE;
      end

      // Receiver: sixteen ticks per bit, samples at ticks 7, 8 and 9.
      if (tick & (s_r.rx_state != astrc_pkg::RX_IDLE)) begin
         s_nxt.rx_ticks = s_r.rx_ticks + 4'h1;
         if (s_r.rx_ticks >= astrc_pkg::SAMPLE_A &&
             s_r.rx_ticks <= astrc_pkg::SAMPLE_C) begin
            s_nxt.samples = {s_r.samples[1:0], s_r.rx_sync};
         end
      end
      unique case (s_r.rx_state)
         astrc_pkg::RX_IDLE: begin
            // A standing overrun blocks new starts until software clears it.
            if (rx_active & ~s_r.overrun & s_r.rx_prev &
                ~s_r.rx_sync) begin
               s_nxt.rx_state = astrc_pkg::RX_START;
               s_nxt.rx_ticks = 4'h0;
               s_nxt.rx_bits = 4'h0;
            end
         end
         astrc_pkg::RX_START: begin
            if (tick) begin
               if (decide(s_r.rx_ticks) && maj) begin
                  s_nxt.rx_state = astrc_pkg::RX_IDLE;
               end else if (s_r.rx_ticks == astrc_pkg::TICKS_LAST) begin
                  s_nxt.rx_state = astrc_pkg::RX_DATA;
               end
            end
         end
         astrc_pkg::RX_DATA: begin
            if (tick) begin
               if (decide(s_r.rx_ticks)) begin
                  s_nxt.receive_shift_register = {maj, s_r.receive_shift_register[8:1]};
               end else if (s_r.rx_ticks == astrc_pkg::TICKS_LAST) begin
                  s_nxt.rx_bits = s_r.rx_bits + 4'h1;
                  if (s_r.rx_bits + 4'h1 == nbits) begin
                     s_nxt.rx_state = astrc_pkg::RX_STOP;
                  end
               end
            end
         end
         astrc_pkg::RX_STOP: begin
            // The stop sample sets this character's framing status and
            // ends the frame early, leaving time to catch the next start.
            if (tick && decide(s_r.rx_ticks)) begin
               s_nxt.rx_state = astrc_pkg::RX_IDLE;
               keep = ~(s_r.ctrl[astrc_pkg::CTRL_ADDR_DET] &
                        s_r.ctrl[astrc_pkg::CTRL_RX9] &
                        ~char_bits[8]);
               if (keep) begin
                  if (s_r.count == astrc_pkg::FIFO_DEPTH & ~pop) begin
                     s_nxt.overrun = 1'b1;
                  end else begin
                     push = 1'b1;
                  end
               end
            end
         end
      endcase
      if (~rx_active) begin
         s_nxt.rx_state = astrc_pkg::RX_IDLE;
      end

      // Receive FIFO; a push and a pop in one cycle keep the count.
      if (push) begin
         s_nxt.fifo[s_r.wptr].data = char_bits[7:0];
         s_nxt.fifo[s_r.wptr].ninth = char_bits[8];
         s_nxt.fifo[s_r.wptr].frame_err = ~maj;
         s_nxt.wptr = ~s_r.wptr;
      end
      if (pop) begin
         s_nxt.rptr = ~s_r.rptr;
      end
      if (push & ~pop) begin
         s_nxt.count = s_r.count + 2'h1;
      end else if (pop & ~push) begin
         s_nxt.count = s_r.count - 2'h1;
      end

      if (~s_r.ctrl[astrc_pkg::CTRL_CRX_EN]) begin
         s_nxt.overrun = 1'b0;
      end
      // Port disable resets the FIFO, buffer and both state machines, stored status included.
      if (~port_en) begin
         s_nxt.overrun = 1'b0;
         s_nxt.count = 2'h0;
         s_nxt.wptr = 1'b0;
         s_nxt.rptr = 1'b0;
         s_nxt.thr_full = 1'b0;
         s_nxt.tx_busy = 1'b0;
         s_nxt.rx_state = astrc_pkg::RX_IDLE;
      end
   end

   // Reset parks the line and its synchroniser at the idle mark level, so
   // no false start edge is seen when reset is released.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.ctrl <= astrc_pkg::CTRL_RESET;
         s_r.baud_div <= astrc_pkg::BAUD_RESET;
         s_r.tx_line <= 1'b1;
         s_r.rx_meta <= 1'b1;
         s_r.rx_sync <= 1'b1;
         s_r.rx_prev <= 1'b1;
         s_r.rx_state <= astrc_pkg::RX_IDLE;
      end else if (ce_i) begin
         s_r <= s_nxt;
      end
   end
endmodule : astrc_core

// file: testbench/astrc_assertions.sv
`timescale 1ns/1ps
module astrc_assertions (
   // Clock, reset and enable.
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // APB.
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Lines and flags.
   input wire logic serial_receive_line_i,
   input wire logic serial_transmit_line_o,
   input wire logic transmit_buffer_empty_flag_o,
   input wire logic receive_data_available_flag_o
);
   logic [8:0] ctrl_r;
   logic ok;
   logic ctrl_wr;
   logic txf;
   logic rxf;
   assign txf = transmit_buffer_empty_flag_o;
   assign rxf = receive_data_available_flag_o;
   assign ok = psel_i && penable_i && pready_o && !pslverr_o;
   assign ctrl_wr = ok && pwrite_i && paddr_i == astrc_pkg::REG_CTRL;
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ctrl_r <= 9'h000;
      end else if (ctrl_wr) begin
         ctrl_r <= pwdata_i[8:0];
      end
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   apb_ready_a: assert property (psel_i && !penable_i && ce_i ##1
      psel_i && penable_i && ce_i |-> pready_o) else $error("pready late");
   ready_access_a: assert property (pready_o |-> psel_i && penable_i)
      else $error("pready outside access");
   err_ready_a: assert property (pslverr_o |-> pready_o)
      else $error("pslverr without pready");
   tx_off_a: assert property (
      !ctrl_r[astrc_pkg::CTRL_TX_EN] |-> !txf) else $error("tx flag off");
   rx_off_a: assert property (
      !(ctrl_r[astrc_pkg::CTRL_PORT_EN] && !ctrl_r[astrc_pkg::CTRL_SYNC]
      && ctrl_r[astrc_pkg::CTRL_CRX_EN]) |-> !rxf) else $error("rx flag off");
   tx_start_a: assert property (
      ctrl_wr && !ctrl_r[astrc_pkg::CTRL_PORT_EN] &&
      pwdata_i[astrc_pkg::CTRL_PORT_EN] && !pwdata_i[astrc_pkg::CTRL_SYNC] &&
      pwdata_i[astrc_pkg::CTRL_TX_EN] |=> txf) else $error("tx flag unset");
   rx_fall_a: assert property ($fell(rxf) |-> $past(ctrl_wr || ok &&
      !pwrite_i && paddr_i == astrc_pkg::REG_RXDATA)) else $error("rx drop");
   tx_fall_a: assert property ($fell(txf) |-> $past(ctrl_wr || ok &&
      pwrite_i && paddr_i == astrc_pkg::REG_TXDATA)) else $error("tx drop");
   rx_seen_c: cover property ($rose(rxf));
   tx_queued_c: cover property ($fell(txf));
   bad_addr_c: cover property (pslverr_o);
endmodule : astrc_assertions

bind astrc_core astrc_assertions u_astrc_assertions (
   .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .serial_receive_line_i(serial_receive_line_i),
   .serial_transmit_line_o(serial_transmit_line_o),
   .transmit_buffer_empty_flag_o(transmit_buffer_empty_flag_o),
   .receive_data_available_flag_o(receive_data_available_flag_o));

// file: testbench/astrc_remote.sv
`timescale 1ns/1ps
module astrc_remote #(parameter int BIT_CLKS = 16) (
   // Clock.
   input wire logic mclk_i,
   // Lines.
   input wire logic line_from_core_i,
   output logic line_to_core_o
);
   logic [8:0] got_q[$];
   initial line_to_core_o = 1'b1;
   task automatic send(input logic [8:0] d, input int nbits, input logic s);
      @(posedge mclk_i);
      line_to_core_o <= 1'b0;
      repeat (BIT_CLKS) @(posedge mclk_i);
      for (int i = 0; i < nbits; i++) begin
         line_to_core_o <= d[i];
         repeat (BIT_CLKS) @(posedge mclk_i);
      end
      line_to_core_o <= s;
      repeat (BIT_CLKS) @(posedge mclk_i);
      line_to_core_o <= 1'b1;
      @(posedge mclk_i);
   endtask : send
   task automatic runt();
      @(posedge mclk_i);
      line_to_core_o <= 1'b0;
      repeat (BIT_CLKS / 4) @(posedge mclk_i);
      line_to_core_o <= 1'b1;
      repeat (12 * BIT_CLKS) @(posedge mclk_i);
   endtask : runt
   // Nine centre samples: an 8-bit frame leaves its stop bit in bit 8.
   initial begin : watch
      logic [8:0] v;
      forever begin
         @(negedge line_from_core_i);
         repeat (BIT_CLKS / 2) @(posedge mclk_i);
         for (int i = 0; i < 9; i++) begin
            repeat (BIT_CLKS) @(posedge mclk_i);
            v[i] = line_from_core_i;
         end
         got_q.push_back(v);
      end
   end
endmodule : astrc_remote

// file: testbench/test_async_serial_tx_rx_core.sv
`timescale 1ns/1ps
module test_async_serial_tx_rx_core;
   localparam int BIT_CLKS = 16;
   localparam logic [7:0] A_CT = astrc_pkg::REG_CTRL;
   localparam logic [7:0] A_ST = astrc_pkg::REG_STATUS;
   localparam logic [7:0] A_TX = astrc_pkg::REG_TXDATA;
   localparam logic [7:0] A_RX = astrc_pkg::REG_RXDATA;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic rx_line;
   logic tx_line;
   logic txe;
   logic rxa;
   logic [31:0] rd;
   logic rerr;
   int num_errors = 0;
   int samples_checked = 0;
   always #5 mclk_i = ~mclk_i;
   astrc_core u_astrc_core (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o),
      .serial_receive_line_i(rx_line), .serial_transmit_line_o(tx_line),
      .transmit_buffer_empty_flag_o(txe),
      .receive_data_available_flag_o(rxa));
   astrc_remote #(.BIT_CLKS(BIT_CLKS)) u_astrc_remote (.mclk_i(mclk_i),
      .line_from_core_i(tx_line), .line_to_core_o(rx_line));
   task automatic close_out();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      rd = prdata_o;
      rerr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(negedge mclk_i);
      if (n >= 50) begin
         num_errors++;
         close_out();
      end
   endtask : apb
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask : rd_chk
   task automatic got_char(input logic [8:0] e);
      for (int n = 0; n < 4000 && u_astrc_remote.got_q.size() == 0; n++) begin
         @(posedge mclk_i);
      end
      chk(32'(u_astrc_remote.got_q.pop_front()), 32'(e));
      repeat (2 * BIT_CLKS) @(posedge mclk_i);
   endtask : got_char
   initial begin
      repeat (3) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd_chk(A_CT, 32'hffff_ffff, 32'h0);
      apb(1'b1, astrc_pkg::REG_BAUD, 32'h0);
      apb(1'b1, 8'h20, 32'h1);
      chk(32'(rerr), 32'h1);
      apb(1'b1, A_CT, 32'h005);
      chk(32'(txe), 32'h1);
      rd_chk(A_ST, 32'h3, 32'h3);
      apb(1'b1, A_TX, 32'ha5);
      rd_chk(A_ST, 32'h3, 32'h2);
      apb(1'b1, A_TX, 32'h3c);
      chk(32'(txe), 32'h0);
      got_char(9'h1a5);
      got_char(9'h13c);
      rd_chk(A_ST, 32'h3, 32'h3);
      apb(1'b1, A_CT, 32'h115);
      apb(1'b1, A_TX, 32'h5a);
      got_char(9'h15a);
      apb(1'b1, A_CT, 32'h015);
      apb(1'b1, A_TX, 32'hff);
      got_char(9'h0ff);
      apb(1'b1, A_CT, 32'h009);
      u_astrc_remote.send(9'h041, 8, 1'b1);
      u_astrc_remote.send(9'h082, 8, 1'b0);
      u_astrc_remote.send(9'h013, 8, 1'b1);
      chk(32'(rxa), 32'h1);
      rd_chk(A_ST, 32'h1c, 32'h14);
      rd_chk(A_RX, 32'hffff_ffff, 32'h41);
      rd_chk(A_ST, 32'h1c, 32'h1c);
      rd_chk(A_RX, 32'hffff_ffff, 32'h82);
      u_astrc_remote.send(9'h055, 8, 1'b1);
      chk(32'(rxa), 32'h0);
      apb(1'b1, A_CT, 32'h001);
      rd_chk(A_ST, 32'h10, 32'h0);
      apb(1'b1, A_CT, 32'h009);
      u_astrc_remote.runt();
      chk(32'(rxa), 32'h0);
      u_astrc_remote.send(9'h066, 8, 1'b1);
      rd_chk(A_RX, 32'hffff_ffff, 32'h66);
      apb(1'b1, A_CT, 32'h00b);
      u_astrc_remote.send(9'h077, 8, 1'b1);
      chk(32'(rxa), 32'h0);
      apb(1'b1, A_CT, 32'h009);
      u_astrc_remote.send(9'h011, 8, 1'b0);
      apb(1'b1, A_CT, 32'h001);
      rd_chk(A_ST, 32'h08, 32'h08);
      apb(1'b1, A_CT, 32'h000);
      rd_chk(A_ST, 32'h1c, 32'h0);
      apb(1'b1, A_CT, 32'h069);
      u_astrc_remote.send(9'h033, 9, 1'b1);
      u_astrc_remote.send(9'h1a7, 9, 1'b1);
      rd_chk(A_ST, 32'h24, 32'h24);
      rd_chk(A_RX, 32'hffff_ffff, 32'ha7);
      chk(32'(rxa), 32'h0);
      apb(1'b1, A_CT, 32'h029);
      u_astrc_remote.send(9'h0c3, 9, 1'b1);
      rd_chk(A_ST, 32'h24, 32'h04);
      rd_chk(A_RX, 32'hffff_ffff, 32'hc3);
      apb(1'b1, A_CT, 32'h085);
      repeat (4) @(negedge mclk_i);
      chk(32'(tx_line), 32'h0);
      close_out();
   end
   initial begin
      repeat (20000) @(posedge mclk_i);
      num_errors++;
      close_out();
   end
endmodule : test_async_serial_tx_rx_core
